// ### shared/acr_pkg.sv
`default_nettype none
package acr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] POWER_CONTROL_ADDR    = 8'h00;
  localparam logic [7:0] GAIN_EDGE_ADDR        = 8'h01;
  localparam logic [7:0] CONVERTER_CTRL_ADDR   = 8'h02;
  localparam logic [7:0] DIGITAL_VOLUME_ADDR   = 8'h03;
  localparam logic [7:0] SERIAL_PORT_1_ADDR    = 8'h04;
  localparam logic [7:0] SERIAL_PORT_2_ADDR    = 8'h05;
  localparam logic [7:0] SUPPLY_READBACK_ADDR  = 8'h06;
  localparam logic [7:0] LIMITER_1_ADDR        = 8'h07;
  localparam logic [7:0] LIMITER_2_ADDR        = 8'h08;
  localparam logic [7:0] LIMITER_3_ADDR        = 8'h09;
  localparam logic [7:0] STATUS_FLAGS_ADDR     = 8'h0A;
  localparam logic [7:0] FAULT_RECOVERY_ADDR   = 8'h0B;
  localparam int         REG_COUNT             = 12;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0] POWER_CONTROL_RST     = 8'h81;
  localparam logic [7:0] GAIN_EDGE_RST         = 8'h01;
  localparam logic [7:0] CONVERTER_CTRL_RST    = 8'h32;
  localparam logic [7:0] DIGITAL_VOLUME_RST    = 8'h40;
  localparam logic [7:0] SERIAL_PORT_1_RST     = 8'h11;
  localparam logic [7:0] SERIAL_PORT_2_RST     = 8'h00;
  localparam logic [7:0] LIMITER_1_RST         = 8'hA4;
  localparam logic [7:0] LIMITER_2_RST         = 8'h00;
  localparam logic [7:0] LIMITER_3_RST         = 8'h22;
  localparam logic [7:0] FAULT_RECOVERY_RST    = 8'h18;
  localparam logic [7:0] RO_RST                = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int AUTO_SLEEP_ENABLE_BIT = 7;
  localparam int SUPPLY_SENSE_OFF_BIT  = 6;
  localparam int SOFT_RESET_BIT        = 1;
  localparam int MASTER_SLEEP_BIT      = 0;
  localparam int EDGE_SLOW_BIT         = 4;
  localparam int FULL_SCALE_LSB        = 0;
  localparam int STATUS_FLAG_COUNT     = 7;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam int ZERO_RUN_LENGTH       = 2048;

  // Full-scale mapping codes of the analog gain field
  typedef enum logic [1:0] {
    ACR_FS_8V4  = 2'h0,
    ACR_FS_12V6 = 2'h1,
    ACR_FS_14V  = 2'h2,
    ACR_FS_15V  = 2'h3
  } acr_full_scale_e;

endpackage
`default_nettype wire

// ### core/acr_register_bank.sv
`timescale 1ns/1ps
`default_nettype none

module acr_register_bank #(
  parameter int SAMPLE_W = 24,                         // Audio sample width
  parameter int ZERO_RUN = acr_pkg::ZERO_RUN_LENGTH    // Zero samples before sleep
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic                ce_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [7:0]          reg_rdata_o,
  output logic                     reg_rvalid_o,
  input  wire logic                sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] sample_data_i,
  input  wire logic [7:0]          supply_level_i,
  input  wire logic [6:0]          fault_flags_i,
  output logic                     block_reset_o,
  output logic                     low_power_o,
  output logic                     auto_asleep_o,
  output logic                     supply_sense_off_o,
  output logic                     edge_slow_o,
  output logic      [1:0]          amp_full_scale_select_o,
  output logic      [7:0]          converter_control_o,
  output logic      [7:0]          digital_volume_o,
  output logic      [7:0]          serial_port_control_1_o,
  output logic      [7:0]          serial_port_control_2_o,
  output logic      [7:0]          limiter_control_1_o,
  output logic      [7:0]          limiter_control_2_o,
  output logic      [7:0]          limiter_control_3_o,
  output logic      [7:0]          fault_recovery_control_o
);

  // ****************************************************************
  // Design notes
  // ****************************************************************
  // Register port
  //   Byte strobe port stands in for the two-wire front end
  //   A write lands at the edge that takes it
  //   A read answers one cycle later with a valid pulse
  //   Read data holds until the next taken read
  //   Reads and writes may come back to back every cycle
  //   A read and a write in one cycle: the read sees the old value
  //   Offsets past the map read zero, writes there vanish
  //   Writes to the readback and status offsets vanish too
  //
  // Power control byte
  //   Bit 7 enables automatic sleep on a zero run
  //   Bit 6 stops supply sensing and freezes the readback
  //   Bits 5..2 are reserved but stored as written
  //   Bit 1 is a write-only soft reset, never stored
  //   Bit 0 is master sleep; the register port stays alive
  //
  // Gain and edge byte
  //   Bit 4 picks slow low-emission edges
  //   Bits 1..0 pick the full-scale code
  //   Other bits are reserved but stored as written
  //
  // Soft reset
  //   Acts at the edge that takes the write
  //   Reloads every register and clears automatic sleep; master sleep is set again by the 0x81 reload
  //   The written data is dropped: the reset wins
  //   block_reset_o pulses for one cycle afterwards
  //   The read port is left alone by a soft reset,
  //   so a read in flight still returns its answer
  //
  // Automatic sleep
  //   Only valid samples count; idle cycles do not
  //   break a run, so slow sample rates still work
  //   The counter saturates instead of wrapping,
  //   which keeps a long silence from waking the part
  //   Clearing the enable drops sleep and the count
  //   The run length is a parameter so that a bench
  //   can shorten it; silicon keeps the full length
  //
  // Status and readback
  //   Status is live, not sticky: a fault that ends
  //   before software reads it is missed; the trade
  //   is that no clear-on-read path is needed
  //   Both bytes lag their sources by one cycle
  //   Bit 7 of status reads zero
  //
  // Clock enable
  //   Low freezes every register and output
  //   Hard reset acts even while it is low
  //   A soft reset write needs it high, as any write
  //
  // Hazards
  //   Fault and supply inputs must already be
  //   synchronous to clk_i; there is no synchroniser
  //   low_power_o is combinational from flip-flops only,
  //   so it carries no glitch from the bus inputs
  //   Sample data must be stable while its strobe
  //   is high; only the strobe qualifies it
  //   Reserved bits are kept so that a host writing
  //   back what it read changes nothing
  //
  // Reset values
  //   One function holds every reset value so that
  //   hard and soft reset can never disagree

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Value of a register after any reset, hard or soft
  function automatic logic [7:0] reset_value(input logic [7:0] addr);
    case (addr)
      acr_pkg::POWER_CONTROL_ADDR:  reset_value = acr_pkg::POWER_CONTROL_RST;
      acr_pkg::GAIN_EDGE_ADDR:      reset_value = acr_pkg::GAIN_EDGE_RST;
      acr_pkg::CONVERTER_CTRL_ADDR: reset_value = acr_pkg::CONVERTER_CTRL_RST;
      acr_pkg::DIGITAL_VOLUME_ADDR: reset_value = acr_pkg::DIGITAL_VOLUME_RST;
      acr_pkg::SERIAL_PORT_1_ADDR:  reset_value = acr_pkg::SERIAL_PORT_1_RST;
      acr_pkg::SERIAL_PORT_2_ADDR:  reset_value = acr_pkg::SERIAL_PORT_2_RST;
      acr_pkg::LIMITER_1_ADDR:      reset_value = acr_pkg::LIMITER_1_RST;
      acr_pkg::LIMITER_2_ADDR:      reset_value = acr_pkg::LIMITER_2_RST;
      acr_pkg::LIMITER_3_ADDR:      reset_value = acr_pkg::LIMITER_3_RST;
      acr_pkg::FAULT_RECOVERY_ADDR: reset_value = acr_pkg::FAULT_RECOVERY_RST;
      default:                      reset_value = acr_pkg::RO_RST;
    endcase
  endfunction

  // Software may write only the stored control registers
  function automatic logic is_writable(input logic [7:0] addr);
    is_writable = (addr < 8'(acr_pkg::REG_COUNT)) &&
                  (addr != acr_pkg::SUPPLY_READBACK_ADDR) &&
                  (addr != acr_pkg::STATUS_FLAGS_ADDR);
  endfunction

  // ****************************************************************
  // Storage and decode
  // ****************************************************************
  localparam int CNT_W = $clog2(ZERO_RUN + 1);                  // Counter width
  localparam logic [CNT_W-1:0] RUN_LAST = CNT_W'(ZERO_RUN - 1); // Count before the last zero

  logic [7:0]       ctrl_reg [acr_pkg::REG_COUNT];  // Stored control bytes
  logic [7:0]       status_flags;                   // Captured fault flags
  logic [7:0]       supply_readback;                // Captured supply level
  logic [CNT_W-1:0] zero_count;                     // Consecutive zero samples seen
  logic             auto_asleep;                    // Automatic sleep state
  logic             wr_hit;                         // Write to a stored register
  logic             soft_reset;                     // Soft reset request this cycle
  logic             sample_zero;                    // Incoming sample is all zero

  assign wr_hit      = ce_i && reg_wr_i && is_writable(reg_addr_i);
  // Soft reset acts only on a write to the power register with the bit set
  assign soft_reset  = ce_i && reg_wr_i && (reg_addr_i == acr_pkg::POWER_CONTROL_ADDR) &&
                       reg_wdata_i[acr_pkg::SOFT_RESET_BIT];
  assign sample_zero = (sample_data_i == '0);

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Hard and soft reset both reload the table; soft reset beats the write
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_reset) begin
      for (int i = 0; i < acr_pkg::REG_COUNT; i++) begin
        ctrl_reg[i] <= reset_value(8'(i));
      end
    end else if (wr_hit) begin
      if (reg_addr_i == acr_pkg::POWER_CONTROL_ADDR) begin
        // Soft reset bit is write-only and never stored
        ctrl_reg[reg_addr_i[3:0]] <= reg_wdata_i & ~(8'h01 << acr_pkg::SOFT_RESET_BIT);
      end else begin
        ctrl_reg[reg_addr_i[3:0]] <= reg_wdata_i;
      end
    end
  end

  // ****************************************************************
  // Read-only status capture
  // ****************************************************************

  // Flags are sampled each cycle, so status tracks the fault sources
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_reset) begin
      status_flags <= acr_pkg::RO_RST;
    end else if (ce_i) begin
      // Bit 7 stays reserved and reads zero
      status_flags <= {1'b0, fault_flags_i};
    end
  end

  // Supply level is frozen while sensing is off
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_reset) begin
      supply_readback <= acr_pkg::RO_RST;
    end else if (ce_i && !supply_sense_off_o) begin
      supply_readback <= supply_level_i;
    end
  end

  // ****************************************************************
  // Zero-run detector and automatic sleep
  // ****************************************************************

  // Counter saturates at the run length so it cannot wrap back awake
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_reset) begin
      zero_count <= '0;
    end else if (ce_i) begin
      if (!ctrl_reg[0][acr_pkg::AUTO_SLEEP_ENABLE_BIT]) begin
        zero_count <= '0;
      end else if (sample_valid_i && !sample_zero) begin
        zero_count <= '0;
      end else if (sample_valid_i && (zero_count != CNT_W'(ZERO_RUN))) begin
        zero_count <= zero_count + CNT_W'(1);
      end
    end
  end

  // Sleep is entered on the last zero of the run, left on a nonzero sample
  always_ff @(posedge clk_i) begin
    if (srst_i || soft_reset) begin
      auto_asleep <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_reg[0][acr_pkg::AUTO_SLEEP_ENABLE_BIT]) begin
        auto_asleep <= 1'b0;
      end else if (sample_valid_i && !sample_zero) begin
        auto_asleep <= 1'b0;
      end else if (sample_valid_i && (zero_count == RUN_LAST)) begin
        auto_asleep <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************

  // Read data is registered; unmapped offsets answer zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          acr_pkg::SUPPLY_READBACK_ADDR: reg_rdata_o <= supply_readback;
          acr_pkg::STATUS_FLAGS_ADDR:    reg_rdata_o <= status_flags;
          default: begin
            if (reg_addr_i < 8'(acr_pkg::REG_COUNT)) begin
              reg_rdata_o <= ctrl_reg[reg_addr_i[3:0]];
            end else begin
              reg_rdata_o <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Reset pulse to the functional blocks
  // ****************************************************************

  // One-cycle pulse after a soft reset; also held through a hard reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      block_reset_o <= 1'b1;
    end else if (ce_i) begin
      block_reset_o <= soft_reset;
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************

  // Master sleep or automatic sleep idles everything but this register port
  assign low_power_o        = ctrl_reg[0][acr_pkg::MASTER_SLEEP_BIT] || auto_asleep;
  assign auto_asleep_o      = auto_asleep;
  assign supply_sense_off_o = ctrl_reg[0][acr_pkg::SUPPLY_SENSE_OFF_BIT];
  assign edge_slow_o        = ctrl_reg[1][acr_pkg::EDGE_SLOW_BIT];
  assign amp_full_scale_select_o = ctrl_reg[1][acr_pkg::FULL_SCALE_LSB +: 2];

  // Remaining bytes feed blocks whose fields are decoded elsewhere
  assign converter_control_o      = ctrl_reg[2];
  assign digital_volume_o         = ctrl_reg[3];
  assign serial_port_control_1_o  = ctrl_reg[4];
  assign serial_port_control_2_o  = ctrl_reg[5];
  assign limiter_control_1_o      = ctrl_reg[7];
  assign limiter_control_2_o      = ctrl_reg[8];
  assign limiter_control_3_o      = ctrl_reg[9];
  assign fault_recovery_control_o = ctrl_reg[11];

endmodule
`default_nettype wire

// ### verification/acr_register_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker for the register bank
// ****************************************************************
module acr_register_bank_checker #(
  parameter int SAMPLE_W = 24                        // Audio sample width
) (
  input wire logic                clk_i,
  input wire logic                srst_i,
  input wire logic                ce_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic [7:0]          reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire logic [7:0]          reg_rdata_o,
  input wire logic                reg_rvalid_o,
  input wire logic                sample_valid_i,
  input wire logic [SAMPLE_W-1:0] sample_data_i,
  input wire logic                block_reset_o,
  input wire logic                low_power_o,
  input wire logic                auto_asleep_o,
  input wire logic                supply_sense_off_o,
  input wire logic                edge_slow_o,
  input wire logic [1:0]          amp_full_scale_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic wr0;                                         // Taken write to power control
  logic wr1;                                         // Taken write to gain and edge
  assign wr0 = ce_i && reg_wr_i && (reg_addr_i == 8'h00);
  assign wr1 = ce_i && reg_wr_i && (reg_addr_i == 8'h01);

  reset_state_a: assert property (disable iff (1'b0) srst_i |=> block_reset_o && low_power_o && !auto_asleep_o) else $error("reset state wrong");
  read_answer_a: assert property (ce_i && reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  status_top_a: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h0A |=> !reg_rdata_o[7]) else $error("status bit 7 set");
  sleep_cause_a: assert property ($rose(auto_asleep_o) |-> $past(sample_valid_i) && $past(sample_data_i) == '0) else $error("sleep without zero sample");
  sleep_power_a: assert property (auto_asleep_o |-> low_power_o) else $error("asleep but powered");
  wake_sample_a: assert property (ce_i && sample_valid_i && sample_data_i != '0 |=> !auto_asleep_o) else $error("no wake on nonzero");
  master_sleep_a: assert property (wr0 && reg_wdata_i[1:0] == 2'h1 |=> low_power_o) else $error("master sleep ignored");
  auto_off_a: assert property (wr0 && reg_wdata_i[7] == 1'b0 && reg_wdata_i[1:0] == 2'h0 |=> !auto_asleep_o && !low_power_o) else $error("disable kept sleep");
  sense_off_a: assert property (wr0 && !reg_wdata_i[1] |=> supply_sense_off_o == $past(reg_wdata_i[6])) else $error("sense bit wrong");
  edge_gain_a: assert property (wr1 |=> edge_slow_o == $past(reg_wdata_i[4]) && amp_full_scale_select_o == $past(reg_wdata_i[1:0])) else $error("gain edge wrong");
  soft_reset_a: assert property (wr0 && reg_wdata_i[1] |=> block_reset_o && !edge_slow_o && amp_full_scale_select_o == 2'h1 && !supply_sense_off_o ##1 !block_reset_o) else $error("soft reset wrong");

  // Main scenarios reached
  sleep_c: cover property ($rose(auto_asleep_o));
  soft_c: cover property (wr0 && reg_wdata_i[1]);
  status_c: cover property (ce_i && reg_rd_i && reg_addr_i == 8'h0A);
endmodule

bind acr_register_bank acr_register_bank_checker #(.SAMPLE_W(SAMPLE_W)) u_acr_register_bank_checker (
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .sample_valid_i(sample_valid_i),
  .sample_data_i(sample_data_i), .block_reset_o(block_reset_o), .low_power_o(low_power_o),
  .auto_asleep_o(auto_asleep_o), .supply_sense_off_o(supply_sense_off_o),
  .edge_slow_o(edge_slow_o), .amp_full_scale_select_o(amp_full_scale_select_o));
`default_nettype wire

// ### verification/acr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Control host model driving the byte strobe port
// ****************************************************************
module acr_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // Idle bus at time zero
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end
  // One write strobe; address and data inverted afterwards so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
    #1;
  endtask
  // One read; a missing answer leaves unknown data, which the bench counts as a mismatch
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 'x;
    @(posedge clk_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge clk_i);
    {addr_o, rd_o} <= {~a, 1'b0};
    #1;
    for (int i = 0; i < 4 && rvalid_i !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (rvalid_i === 1'b1) begin
      d = rdata_i;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/amp_control_register_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module amp_control_register_bank_bench;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic        clk_i = 1'b0;                         // 200 MHz clock
  logic        srst_i = 1'b1;                        // Held for 12 cycles
  logic        sv = 1'b0;                            // Sample strobe
  logic [23:0] sd = '0;                              // Sample value
  logic [7:0]  sup = '0;                             // Supply level seen by sensing
  logic [6:0]  flt = '0;                             // Fault flag levels
  logic [7:0]  addr, wdata, rdata, rv;
  logic        wr, rd, rvalid, brst, lp, asleep, sso, es;
  logic [1:0]  fs;
  logic        ce = 1'b1;                            // Clock enable
  logic [7:0]  pt [8];                               // Stored bytes fed to other blocks
  int          errors = 0;
  int          samples_checked = 0;
  logic [7:0]  rst_tab [12] = '{8'h81, 8'h01, 8'h32, 8'h40, 8'h11, 8'h00,
                                 8'h00, 8'hA4, 8'h00, 8'h22, 8'h00, 8'h18};
  always #2.5 clk_i = ~clk_i;

  // Short zero run keeps the sleep scenarios brief
  acr_register_bank #(.SAMPLE_W(24), .ZERO_RUN(8)) u_acr_register_bank (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .sample_valid_i(sv), .sample_data_i(sd), .supply_level_i(sup), .fault_flags_i(flt),
    .block_reset_o(brst), .low_power_o(lp), .auto_asleep_o(asleep),
    .supply_sense_off_o(sso), .edge_slow_o(es), .amp_full_scale_select_o(fs),
    .converter_control_o(pt[0]), .digital_volume_o(pt[1]), .serial_port_control_1_o(pt[2]),
    .serial_port_control_2_o(pt[3]), .limiter_control_1_o(pt[4]), .limiter_control_2_o(pt[5]),
    .limiter_control_3_o(pt[6]), .fault_recovery_control_o(pt[7]));
  acr_host_model u_acr_host_model (
    .clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Holds the strobe high for n back-to-back samples of one value
  task automatic smp(input logic [23:0] d, input int n);
    @(posedge clk_i);
    {sv, sd} <= {1'b1, d};
    repeat (n) @(posedge clk_i);
    sv <= 1'b0;
    #1;
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    // Every offset after reset, plus one unmapped offset reading zero
    for (int i = 0; i < 13; i++) begin
      u_acr_host_model.rd(i[7:0], rv);
      chk("reset value", rv, (i < 12) ? rst_tab[i] : 8'h00);
    end
    // Byte outputs carry the stored reset values
    for (int k = 0; k < 8; k++) begin
      chk("byte output", pt[k], rst_tab[(k < 4) ? k + 2 : (k < 7) ? k + 3 : 11]);
    end
    // Every full-scale code with the slow edge set
    for (int g = 0; g < 4; g++) begin
      u_acr_host_model.wr(8'h01, {3'h0, 1'b1, 2'h0, g[1:0]});
      chk("full scale", {6'h0, fs}, g[7:0]);
      chk("edge slow", {7'h0, es}, 8'h01);
    end
    u_acr_host_model.wr(8'h01, 8'h00);
    chk("edge normal", {7'h0, es}, 8'h00);
    // Sensing on captures, sensing off freezes the readback
    @(posedge clk_i) sup <= 8'h3C;
    u_acr_host_model.wr(8'h00, 8'h80);
    chk("powered", {7'h0, lp}, 8'h00);
    u_acr_host_model.rd(8'h06, rv);
    chk("supply", rv, 8'h3C);
    u_acr_host_model.wr(8'h00, 8'hC0);
    chk("sense off", {7'h0, sso}, 8'h01);
    @(posedge clk_i) sup <= 8'h77;
    u_acr_host_model.rd(8'h06, rv);
    chk("supply frozen", rv, 8'h3C);
    // Master sleep keeps registers reachable
    u_acr_host_model.wr(8'h00, 8'h81);
    chk("master sleep", {7'h0, lp}, 8'h01);
    u_acr_host_model.rd(8'h00, rv);
    chk("asleep read", rv, 8'h81);
    u_acr_host_model.wr(8'h00, 8'h80);
    // One short of the run, then the run itself, then a wake
    smp(24'h0, 7);
    chk("no sleep yet", {7'h0, asleep}, 8'h00);
    smp(24'h0, 1);
    chk("auto sleep", {6'h0, asleep, lp}, 8'h03);
    smp(24'h1, 1);
    chk("woken", {6'h0, asleep, lp}, 8'h00);
    // A nonzero sample mid-run restarts the count
    smp(24'h0, 4);
    smp(24'h800000, 1);
    smp(24'h0, 7);
    chk("run restarted", {7'h0, asleep}, 8'h00);
    smp(24'h0, 1);
    chk("sleep again", {7'h0, asleep}, 8'h01);
    smp(24'h2, 1);
    // Disabling mid-run clears the count
    smp(24'h0, 5);
    u_acr_host_model.wr(8'h00, 8'h00);
    u_acr_host_model.wr(8'h00, 8'h80);
    smp(24'h0, 7);
    chk("disable cleared", {7'h0, asleep}, 8'h00);
    // Status follows the flags; a write there is ignored
    @(posedge clk_i) flt <= 7'h55;
    u_acr_host_model.wr(8'h0A, 8'hFF);
    u_acr_host_model.rd(8'h0A, rv);
    chk("status", rv, 8'h55);
    // A write while the clock enable is low is not taken
    @(posedge clk_i) ce <= 1'b0;
    u_acr_host_model.wr(8'h01, 8'h13);
    @(posedge clk_i) ce <= 1'b1;
    u_acr_host_model.rd(8'h01, rv);
    chk("frozen write", rv, 8'h00);
    // Soft reset discards earlier writes
    u_acr_host_model.wr(8'h01, 8'h12);
    u_acr_host_model.wr(8'h00, 8'h42);
    chk("block reset", {7'h0, brst}, 8'h01);
    u_acr_host_model.rd(8'h01, rv);
    chk("gain restored", rv, 8'h01);
    u_acr_host_model.rd(8'h00, rv);
    chk("power restored", rv, 8'h81);
    wrap_up();
  end
endmodule
`default_nettype wire
